// ---- cfd_pkg.sv ----
// constants and types shared by the link flag and data register block
package cfd_pkg;
  // ----------------------------------------
  // bus geometry
  // ----------------------------------------
  localparam int ADDR_W  = 6;
  localparam int DATA_W  = 32;
  localparam int BE_W    = 4;
  localparam int BYTE_W  = 8;
  localparam int OA_W    = 4;
  localparam int PRESC_W = 14;
  localparam int ESR_W   = 7;
  localparam int FLAG_W  = 6;
  localparam int EVT_W   = 4;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] OFS_LINK_CONFIG  = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_OWN_ADDRESS  = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_PRESCALER    = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_ERROR_DETAIL = 6'h0C;
  localparam logic [ADDR_W-1:0] OFS_CTRL_STATUS  = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_TX_DATA      = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_RX_DATA      = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_EVT_STATUS   = 6'h1C;
  localparam logic [ADDR_W-1:0] OFS_EVT_MASK     = 6'h20;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CFG_PE_BIT   = 0;
  localparam int CFG_IE_BIT   = 1;
  localparam int CFG_BTEM_BIT = 2;
  localparam int CFG_BPEM_BIT = 3;
  localparam int CSR_TX_BEGIN_MESSAGE_BIT = 0;
  localparam int CSR_TX_LAST_BYTE_BIT = 1;
  localparam int CSR_FLAG_LSB = 2;
  // flag vector order, bit 0 = control_status bit 2
  localparam int FL_TX_FAULT   = 0;
  localparam int FL_TX_NEXT    = 1;
  localparam int FL_RX_HEADER  = 2;
  localparam int FL_RX_LAST    = 3;
  localparam int FL_RX_FAULT   = 4;
  localparam int FL_RX_DONE    = 5;
  // event status / mask order
  localparam int EV_RX_DONE  = 0;
  localparam int EV_RX_FAULT = 1;
  localparam int EV_TX_NEXT  = 2;
  localparam int EV_TX_FAULT = 3;
  // error detail groups
  localparam logic [ESR_W-1:0] ESR_TX_MASK = 7'h70;
  localparam logic [ESR_W-1:0] ESR_RX_MASK = 7'h1F;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [DATA_W-1:0] RST_WORD = 32'h00000000;
  localparam logic [EVT_W-1:0]  RST_MASK = 4'h0;
  typedef enum logic [0:0] {
    CFD_BUS_IDLE = 1'b0,
    CFD_BUS_ACK  = 1'b1
  } cfd_bus_t;
endpackage : cfd_pkg

// ---- cfd_link_regs.sv ----
// register file, event flags and data bytes of the single-wire link controller
// Summary of operation
// - a finished received byte sets rx_byte_done.
// - with irq_enable set, any of rx_byte_done, rx_fault, tx_next_or_done, tx_fault raises irq.
// - the six event flags clear only on a written zero; a written one leaves them alone.
// - a reception error sets rx_fault and its cause lands in error_detail.
// - the last byte of a message also sets rx_last_byte.
// - a header byte also sets rx_header_seen.
// - tx_next_or_done asks for the next byte, or reports a sent message when tx_last_byte is set.
// - a transmission error sets tx_fault and its cause lands in error_detail.
// - software sets and clears tx_last_byte, except while rx_byte_done or rx_fault is set.
// - the current byte goes out with its end bit equal to tx_last_byte.
// - software loads the header first; setting tx_begin_message asks for a new message.
// - tx_begin_message self-clears on bus grant or on a transmission error.
// - the byte to send comes from the read-write tx_data field.
// - the last received byte is shown in the read-only rx_data field.
// - clearing tx_fault clears the tx error details, clearing rx_fault the rx ones.
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module cfd_link_regs
  import cfd_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire logic [ADDR_W-1:0] avs_address_in,
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  input  wire logic [DATA_W-1:0] avs_writedata_in,
  input  wire logic [BE_W-1:0]   avs_byteenable_in,
  output var  logic [DATA_W-1:0] avs_readdata_out,
  output var  logic              avs_waitrequest_out,
  output var  logic              irq_out,
  input  wire logic              rx_byte_valid_in,
  input  wire logic [BYTE_W-1:0] rx_byte_in,
  input  wire logic              rx_last_in,
  input  wire logic              rx_header_in,
  input  wire logic              rx_error_in,
  input  wire logic              tx_request_in,
  input  wire logic              tx_error_in,
  input  wire logic [ESR_W-1:0]  err_cause_in,
  input  wire logic              bus_granted_in,
  input  wire logic              link_idle_in,
  output var  logic              link_enable_out,
  output var  logic              timing_err_mode_out,
  output var  logic              period_err_mode_out,
  output var  logic [OA_W-1:0]   own_address_out,
  output var  logic [PRESC_W-1:0] prescaler_out,
  output var  logic [BYTE_W-1:0] tx_data_out,
  output var  logic              tx_last_byte_out,
  output var  logic              tx_begin_message_out,
  output var  logic              rx_byte_done_out,
  output var  logic              tx_next_or_done_out
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [DATA_W-1:0] lane_mask(input logic [BE_W-1:0] be);
    logic [DATA_W-1:0] m;
    m = RST_WORD;
    for (int i = 0; i < BE_W; i++)
    begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction : lane_mask

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_meta_reg;
  logic rst_sync_reg;
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  wire logic rst_n = rst_sync_reg;

  // ----------------------------------------
  // bus handshake
  // ----------------------------------------
  // one wait cycle always; read data is latched at the same edge that drops waitrequest
  cfd_bus_t          bus_reg;
  cfd_bus_t          bus_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rd_word;
  logic              wait_reg;
  wire logic req = avs_read_in | avs_write_in;
  wire logic acc = (bus_reg == CFD_BUS_ACK);
  wire logic wr  = avs_write_in & acc;
  wire logic [DATA_W-1:0] wmask = lane_mask(avs_byteenable_in);
  wire logic [DATA_W-1:0] wset  = avs_writedata_in & wmask;
  wire logic [DATA_W-1:0] wzero = ~avs_writedata_in & wmask;
  assign bus_next = (!acc && req) ? CFD_BUS_ACK : CFD_BUS_IDLE;

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic                pe_reg;
  logic                pe_off_reg;
  logic                ie_reg;
  logic                btem_reg;
  logic                bpem_reg;
  logic [OA_W-1:0]     oa_reg;
  logic [PRESC_W-1:0]  presc_reg;
  logic [ESR_W-1:0]    esr_reg;
  logic [FLAG_W-1:0]   flag_reg;
  logic                tx_last_byte_reg;
  logic                tx_begin_message_reg;
  logic [BYTE_W-1:0]   txd_reg;
  logic [BYTE_W-1:0]   rxd_reg;
  logic [EVT_W-1:0]    evt_reg;
  logic [EVT_W-1:0]    emask_reg;
  logic                irq_reg;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  wire logic wr_cfg  = wr & (avs_address_in == OFS_LINK_CONFIG);
  wire logic wr_oa   = wr & (avs_address_in == OFS_OWN_ADDRESS);
  wire logic wr_pre  = wr & (avs_address_in == OFS_PRESCALER);
  wire logic wr_csr  = wr & (avs_address_in == OFS_CTRL_STATUS);
  wire logic wr_txd  = wr & (avs_address_in == OFS_TX_DATA);
  wire logic wr_evt  = wr & (avs_address_in == OFS_EVT_STATUS);
  wire logic wr_emsk = wr & (avs_address_in == OFS_EVT_MASK);

  always_comb
  begin
    rd_word = RST_WORD;
    if (avs_address_in == OFS_LINK_CONFIG)
      rd_word[3:0] = {bpem_reg, btem_reg, ie_reg, pe_reg};
    else if (avs_address_in == OFS_OWN_ADDRESS)
      rd_word[OA_W-1:0] = oa_reg;
    else if (avs_address_in == OFS_PRESCALER)
      rd_word[PRESC_W-1:0] = presc_reg;
    else if (avs_address_in == OFS_ERROR_DETAIL)
      rd_word[ESR_W-1:0] = esr_reg;
    else if (avs_address_in == OFS_CTRL_STATUS)
      rd_word[BYTE_W-1:0] = {flag_reg, tx_last_byte_reg, tx_begin_message_reg};
    else if (avs_address_in == OFS_TX_DATA)
      rd_word[BYTE_W-1:0] = txd_reg;
    else if (avs_address_in == OFS_RX_DATA)
      rd_word[BYTE_W-1:0] = rxd_reg;
    else if (avs_address_in == OFS_EVT_STATUS)
      rd_word[EVT_W-1:0] = evt_reg;
    else if (avs_address_in == OFS_EVT_MASK)
      rd_word[EVT_W-1:0] = emask_reg;
    else
      rd_word = RST_WORD;
  end

  // ----------------------------------------
  // event flags
  // ----------------------------------------
  logic [FLAG_W-1:0] flag_set;
  logic [FLAG_W-1:0] flag_clr;
  logic [FLAG_W-1:0] flag_next;
  assign flag_set[FL_RX_DONE]   = rx_byte_valid_in;
  assign flag_set[FL_RX_FAULT]  = rx_error_in;
  assign flag_set[FL_RX_LAST]   = rx_byte_valid_in & rx_last_in;
  assign flag_set[FL_RX_HEADER] = rx_byte_valid_in & rx_header_in;
  assign flag_set[FL_TX_NEXT]   = tx_request_in;
  assign flag_set[FL_TX_FAULT]  = tx_error_in;
  // only a written zero in an enabled lane clears; set wins
  assign flag_clr  = wr_csr ? wzero[CSR_FLAG_LSB +: FLAG_W] : '0;
  assign flag_next = flag_set | (flag_reg & ~flag_clr);

  // ----------------------------------------
  // error detail
  // ----------------------------------------
  // ack error sits in both groups, so either fault clear drops it
  wire logic [ESR_W-1:0] esr_clr =
    (flag_clr[FL_TX_FAULT] ? ESR_TX_MASK : '0) |
    (flag_clr[FL_RX_FAULT] ? ESR_RX_MASK : '0);
  wire logic [ESR_W-1:0] esr_next = err_cause_in | (esr_reg & ~esr_clr);

  // ----------------------------------------
  // message framing controls
  // ----------------------------------------
  // a byte being received must not race a framing change
  wire logic tx_last_byte_lock = flag_reg[FL_RX_DONE] | flag_reg[FL_RX_FAULT];
  wire logic tx_last_byte_wr   = wr_csr & avs_byteenable_in[0] & ~tx_last_byte_lock;
  wire logic tx_last_byte_next = tx_last_byte_wr ? avs_writedata_in[CSR_TX_LAST_BYTE_BIT] : tx_last_byte_reg;
  wire logic tx_begin_message_set  = wr_csr & wset[CSR_TX_BEGIN_MESSAGE_BIT];
  wire logic tx_begin_message_clr  = bus_granted_in | tx_error_in;
  wire logic tx_begin_message_next = tx_begin_message_set | (tx_begin_message_reg & ~tx_begin_message_clr);

  // ----------------------------------------
  // link enable
  // ----------------------------------------
  // disable waits for the engine to go idle so a frame is never cut
  wire logic pe_set      = wr_cfg & wset[CFG_PE_BIT];
  wire logic pe_off_set  = wr_cfg & wzero[CFG_PE_BIT];
  wire logic pe_drop     = pe_off_reg & link_idle_in;
  wire logic pe_next     = pe_set | (pe_reg & ~pe_drop);
  wire logic pe_off_next = ~pe_set & (pe_off_set | (pe_off_reg & ~pe_drop));

  // ----------------------------------------
  // interrupt
  // ----------------------------------------
  logic [EVT_W-1:0] evt_set;
  assign evt_set[EV_RX_DONE]  = flag_set[FL_RX_DONE];
  assign evt_set[EV_RX_FAULT] = flag_set[FL_RX_FAULT];
  assign evt_set[EV_TX_NEXT]  = flag_set[FL_TX_NEXT];
  assign evt_set[EV_TX_FAULT] = flag_set[FL_TX_FAULT];
  wire logic [EVT_W-1:0] evt_clr  = wr_evt ? wset[EVT_W-1:0] : '0;
  wire logic [EVT_W-1:0] evt_next = evt_set | (evt_reg & ~evt_clr);
  // mask takes effect with its write, like irq_enable, so irq never lags the write
  wire logic [EVT_W-1:0] emask_next = (wr_emsk && avs_byteenable_in[0]) ?
                                      avs_writedata_in[EVT_W-1:0] : emask_reg;
  wire logic flag_irq = flag_next[FL_RX_DONE] | flag_next[FL_RX_FAULT] |
                        flag_next[FL_TX_NEXT] | flag_next[FL_TX_FAULT];
  wire logic ie_next  = wr_cfg & avs_byteenable_in[0] ?
                        avs_writedata_in[CFG_IE_BIT] : ie_reg;
  wire logic irq_next = (ie_next & flag_irq) | (|(evt_next & emask_next));

  // ----------------------------------------
  // clocked state
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_reg  <= CFD_BUS_IDLE;
      wait_reg <= 1'b1;
      rdata_reg <= RST_WORD;
    end
    else
    begin
      bus_reg  <= bus_next;
      wait_reg <= (bus_next != CFD_BUS_ACK);
      rdata_reg <= (bus_next == CFD_BUS_ACK && avs_read_in) ? rd_word : RST_WORD;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pe_reg     <= 1'b0;
      pe_off_reg <= 1'b0;
      ie_reg     <= 1'b0;
      btem_reg   <= 1'b0;
      bpem_reg   <= 1'b0;
    end
    else
    begin
      pe_reg     <= pe_next;
      pe_off_reg <= pe_off_next;
      ie_reg     <= ie_next;
      if (wr_cfg && avs_byteenable_in[0])
      begin
        btem_reg <= avs_writedata_in[CFG_BTEM_BIT];
        bpem_reg <= avs_writedata_in[CFG_BPEM_BIT];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      oa_reg    <= '0;
      presc_reg <= '0;
      txd_reg   <= '0;
    end
    else
    begin
      if (wr_oa && avs_byteenable_in[0])
        oa_reg <= avs_writedata_in[OA_W-1:0];
      if (wr_pre)
        presc_reg <= (presc_reg & ~wmask[PRESC_W-1:0]) | wset[PRESC_W-1:0];
      if (wr_txd && avs_byteenable_in[0])
        txd_reg <= avs_writedata_in[BYTE_W-1:0];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag_reg  <= '0;
      esr_reg   <= '0;
      tx_last_byte_reg  <= 1'b0;
      tx_begin_message_reg  <= 1'b0;
      rxd_reg   <= '0;
    end
    else
    begin
      flag_reg <= flag_next;
      esr_reg  <= esr_next;
      tx_last_byte_reg <= tx_last_byte_next;
      tx_begin_message_reg <= tx_begin_message_next;
      if (rx_byte_valid_in)
        rxd_reg <= rx_byte_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      evt_reg   <= '0;
      emask_reg <= RST_MASK;
      irq_reg   <= 1'b0;
    end
    else
    begin
      evt_reg   <= evt_next;
      emask_reg <= emask_next;
      irq_reg <= irq_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign avs_readdata_out     = rdata_reg;
  assign avs_waitrequest_out  = wait_reg;
  assign irq_out              = irq_reg;
  assign link_enable_out      = pe_reg;
  assign timing_err_mode_out  = btem_reg;
  assign period_err_mode_out  = bpem_reg;
  assign own_address_out      = oa_reg;
  assign prescaler_out        = presc_reg;
  assign tx_data_out          = txd_reg;
  assign tx_last_byte_out     = tx_last_byte_reg;
  assign tx_begin_message_out = tx_begin_message_reg;
  assign rx_byte_done_out     = flag_reg[FL_RX_DONE];
  assign tx_next_or_done_out  = flag_reg[FL_TX_NEXT];
endmodule : cfd_link_regs
`default_nettype wire

// ---- cfd_link_regs_checker.sv ----
// assertions on the ports of the link register block
`timescale 1ns/1ns
`default_nettype none
module cfd_link_regs_checker
  import cfd_pkg::*;
(
  input wire logic              clk_in,
  input wire logic              rst_n_in,
  input wire logic [ADDR_W-1:0] avs_address_in,
  input wire logic              avs_write_in,
  input wire logic [DATA_W-1:0] avs_writedata_in,
  input wire logic [BE_W-1:0]   avs_byteenable_in,
  input wire logic              avs_waitrequest_out,
  input wire logic              irq_out,
  input wire logic              rx_byte_valid_in,
  input wire logic              rx_error_in,
  input wire logic              tx_request_in,
  input wire logic              tx_error_in,
  input wire logic              bus_granted_in,
  input wire logic [BYTE_W-1:0] tx_data_out,
  input wire logic              tx_last_byte_out,
  input wire logic              tx_begin_message_out,
  input wire logic              rx_byte_done_out,
  input wire logic              tx_next_or_done_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // a write counts only at the edge that sees waitrequest low
  wire              wr_ok    = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
  wire              csr_wr   = wr_ok && (avs_address_in == OFS_CTRL_STATUS);
  wire              tx_begin_message_set = csr_wr && avs_writedata_in[CSR_TX_BEGIN_MESSAGE_BIT];
  wire              rbd_clr  = csr_wr && !avs_writedata_in[7];
  wire [BYTE_W-1:0] wbyte    = avs_writedata_in[BYTE_W-1:0];
  a_rx_done_set: assert property (rx_byte_valid_in |=> rx_byte_done_out)
    else $error("rx byte left done flag low");
  a_flag_holds: assert property (rx_byte_done_out && !rbd_clr |=> rx_byte_done_out)
    else $error("done flag dropped without a written zero");
  a_flag_clears: assert property (rbd_clr && !rx_byte_valid_in |=> !rx_byte_done_out)
    else $error("written zero left done flag set");
  a_irq_cause: assert property ($rose(irq_out) |->
    $past(rx_byte_valid_in || rx_error_in || tx_request_in || tx_error_in || avs_write_in))
    else $error("irq rose with no event or write");
  a_last_locked: assert property (csr_wr && rx_byte_done_out |=> $stable(tx_last_byte_out))
    else $error("end bit changed while rx flag set");
  a_begin_set: assert property (tx_begin_message_set |=> tx_begin_message_out)
    else $error("begin bit not set by write");
  a_begin_drop: assert property ((bus_granted_in || tx_error_in) && !tx_begin_message_set
    |=> !tx_begin_message_out)
    else $error("begin bit survived grant or error");
  a_tx_next: assert property (tx_request_in |=> tx_next_or_done_out)
    else $error("tx request left flag low");
  a_tx_byte: assert property (wr_ok && avs_address_in == OFS_TX_DATA
    |=> tx_data_out == $past(wbyte))
    else $error("tx byte not taken from write");
  c_rx_byte: cover property (rx_byte_valid_in ##1 rx_byte_done_out);
  c_granted: cover property (tx_begin_message_out ##1 bus_granted_in);
  c_irq: cover property ($rose(irq_out));
endmodule : cfd_link_regs_checker
bind cfd_link_regs cfd_link_regs_checker u_chk (.clk_in, .rst_n_in, .avs_address_in,
  .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_waitrequest_out, .irq_out,
  .rx_byte_valid_in, .rx_error_in, .tx_request_in, .tx_error_in, .bus_granted_in,
  .tx_data_out, .tx_last_byte_out, .tx_begin_message_out, .rx_byte_done_out,
  .tx_next_or_done_out);
`default_nettype wire

// ---- cfd_engine_model.sv ----
// behavioural bit engine that feeds link events to the register block
`timescale 1ns/1ns
`default_nettype none
module cfd_engine_model
  import cfd_pkg::*;
(
  input  wire logic              clk_in,
  output var  logic              rx_byte_valid_out,
  output var  logic [BYTE_W-1:0] rx_byte_out,
  output var  logic              rx_last_out,
  output var  logic              rx_header_out,
  output var  logic              rx_error_out,
  output var  logic              tx_request_out,
  output var  logic              tx_error_out,
  output var  logic [ESR_W-1:0]  err_cause_out,
  output var  logic              bus_granted_out,
  output var  logic              link_idle_out
);
  initial
  begin
    {rx_header_out, rx_last_out, bus_granted_out, tx_error_out} = 4'h0;
    {tx_request_out, rx_error_out, rx_byte_valid_out} = 3'h0;
    rx_byte_out = 8'h00;
    err_cause_out = 7'h00;
    link_idle_out = 1'b1;
  end
  // k = {header, last, grant, tx error, tx request, rx error, rx byte}
  task automatic ev(input logic [6:0] k, input logic [7:0] b, input logic [6:0] c);
    @(posedge clk_in);
    {rx_header_out, rx_last_out, bus_granted_out, tx_error_out,
     tx_request_out, rx_error_out, rx_byte_valid_out} <= k;
    rx_byte_out <= b;
    err_cause_out <= c;
    @(posedge clk_in);
    // released data lines show the inverse, strobes drop
    {rx_header_out, rx_last_out, bus_granted_out, tx_error_out,
     tx_request_out, rx_error_out, rx_byte_valid_out} <= {~k[6:5], 5'h00};
    rx_byte_out <= ~b;
    err_cause_out <= 7'h00;
    @(posedge clk_in);
  endtask : ev
endmodule : cfd_engine_model
`default_nettype wire

// ---- cfd_tb.sv ----
// self-checking bench for the link register block
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("FAIL %s exp %h got %h", n, e, g); end end
module tb
  import cfd_pkg::*;
;
  logic              clk_in, rst_n_in, rd, wr, wq, irq, rbv, rl, rh, re, tq, te, bg, li;
  logic              tlb, tbm, rdo, tnd, pe, tmo, pmo;
  logic [OA_W-1:0]   oa;
  logic [PRESC_W-1:0] pre;
  logic [ADDR_W-1:0] adr, a;
  logic [DATA_W-1:0] wd, rdat, v, d;
  logic [BE_W-1:0]   be;
  logic [BYTE_W-1:0] rb, txd;
  logic [ESR_W-1:0]  ec;
  integer            seed, mismatches, cmp_count;
  cfd_link_regs dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wq), .irq_out(irq),
    .rx_byte_valid_in(rbv), .rx_byte_in(rb), .rx_last_in(rl), .rx_header_in(rh),
    .rx_error_in(re), .tx_request_in(tq), .tx_error_in(te), .err_cause_in(ec),
    .bus_granted_in(bg), .link_idle_in(li), .link_enable_out(pe), .timing_err_mode_out(tmo),
    .period_err_mode_out(pmo), .own_address_out(oa), .prescaler_out(pre), .tx_data_out(txd),
    .tx_last_byte_out(tlb), .tx_begin_message_out(tbm), .rx_byte_done_out(rdo),
    .tx_next_or_done_out(tnd));
  cfd_engine_model m (.clk_in(clk_in), .rx_byte_valid_out(rbv), .rx_byte_out(rb),
    .rx_last_out(rl), .rx_header_out(rh), .rx_error_out(re), .tx_request_out(tq),
    .tx_error_out(te), .err_cause_out(ec), .bus_granted_out(bg), .link_idle_out(li));
  // callers keep bits 31:14 zero
  task automatic bw(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] dd);
    adr <= ad;
    wd <= dd;
    wr <= 1'b1;
    do @(posedge clk_in); while (wq !== 1'b0);
    wr <= 1'b0;
    @(posedge clk_in);
  endtask : bw
  task automatic rc(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] e, input string n);
    adr <= ad;
    rd <= 1'b1;
    do @(posedge clk_in); while (wq !== 1'b0);
    v = rdat;
    rd <= 1'b0;
    @(posedge clk_in);
    `CHK(n, e, v)
  endtask : rc
  function automatic logic [DATA_W-1:0] exp_csr(input logic l, input logic h);
    return {24'h0, 2'b10, l, h, 4'h0};
  endfunction : exp_csr
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  // whole run needs well under 3000 cycles
  initial
  begin
    repeat (20000) @(posedge clk_in);
    mismatches++;
    test_done;
  end
  initial
  begin
    {rd, wr, rst_n_in, adr, wd, be} = '0;
    seed = 17;
    mismatches = 0;
    cmp_count = 0;
    be = 4'hF;
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    for (int i = 0; i < 10; i++) rc(6'(4 * i), 32'h0, "reset");
    bw(OFS_LINK_CONFIG, 32'hD);
    `CHK("config outs", 3'h7, {pmo, tmo, pe})
    bw(OFS_OWN_ADDRESS, 32'h9);
    `CHK("own_address_out", 4'h9, oa)
    for (int i = 0; i < 3; i++)
    begin
      a = (i == 0) ? OFS_ERROR_DETAIL : (i == 1) ? OFS_RX_DATA : 6'h24;
      bw(a, 32'hFF);
      rc(a, 32'h0, "read only");
    end
    repeat (6)
    begin
      d = $random(seed);
      bw(OFS_TX_DATA, {24'h0, d[7:0]});
      rc(OFS_TX_DATA, {24'h0, d[7:0]}, "tx_data");
      `CHK("tx_data_out", d[7:0], txd)
      bw(OFS_PRESCALER, {18'h0, d[29:16]});
      rc(OFS_PRESCALER, {18'h0, d[29:16]}, "prescaler");
      `CHK("prescaler_out", d[29:16], pre)
    end
    // header and last together first, then random bytes
    m.ev(7'h61, 8'hC3, 7'h00);
    rc(OFS_CTRL_STATUS, exp_csr(1'b1, 1'b1), "csr rx");
    bw(OFS_CTRL_STATUS, 32'h0);
    repeat (8)
    begin
      d = $random(seed);
      m.ev({d[9:8], 5'h01}, d[7:0], 7'h00);
      `CHK("rx_byte_done_out", 1'b1, rdo)
      rc(OFS_CTRL_STATUS, exp_csr(d[8], d[9]), "csr rx");
      rc(OFS_RX_DATA, {24'h0, d[7:0]}, "rx_data");
      bw(OFS_CTRL_STATUS, 32'h0);
    end
    m.ev(7'h01, 8'h5A, 7'h00);
    bw(OFS_CTRL_STATUS, 32'hFE);
    rc(OFS_CTRL_STATUS, 32'h80, "ones keep");
    bw(OFS_CTRL_STATUS, 32'h7E);
    rc(OFS_CTRL_STATUS, 32'h0, "zero clears");
    bw(OFS_CTRL_STATUS, 32'h02);
    `CHK("end bit", 1'b1, tlb)
    bw(OFS_CTRL_STATUS, 32'h0);
    `CHK("end bit", 1'b0, tlb)
    m.ev(7'h02, 8'h00, 7'h13);
    rc(OFS_CTRL_STATUS, 32'h40, "rx fault");
    rc(OFS_ERROR_DETAIL, 32'h13, "rx cause");
    bw(OFS_CTRL_STATUS, 32'hBC);
    rc(OFS_ERROR_DETAIL, 32'h0, "rx cause clr");
    bw(OFS_TX_DATA, 32'h4F);
    bw(OFS_CTRL_STATUS, 32'hFD);
    `CHK("begin bit", 1'b1, tbm)
    m.ev(7'h08, 8'h00, 7'h71);
    rc(OFS_CTRL_STATUS, 32'h04, "tx fault");
    rc(OFS_ERROR_DETAIL, 32'h71, "tx cause");
    bw(OFS_CTRL_STATUS, 32'hF8);
    rc(OFS_ERROR_DETAIL, 32'h01, "tx cause clr");
    bw(OFS_CTRL_STATUS, 32'hFD);
    m.ev(7'h10, 8'h00, 7'h00);
    `CHK("begin bit", 1'b0, tbm)
    bw(OFS_LINK_CONFIG, 32'h2);
    m.ev(7'h04, 8'h00, 7'h00);
    `CHK("irq", 1'b1, irq)
    `CHK("tx_next_or_done_out", 1'b1, tnd)
    `CHK("link_enable_out", 1'b0, pe)
    bw(OFS_CTRL_STATUS, 32'hF4);
    `CHK("irq", 1'b0, irq)
    bw(OFS_LINK_CONFIG, 32'h0);
    bw(OFS_EVT_STATUS, 32'hF);
    rc(OFS_EVT_STATUS, 32'h0, "evt clr");
    bw(OFS_EVT_MASK, 32'h1);
    m.ev(7'h01, 8'h11, 7'h00);
    `CHK("irq mask", 1'b1, irq)
    bw(OFS_EVT_MASK, 32'h0);
    `CHK("irq mask", 1'b0, irq)
    bw(OFS_EVT_MASK, 32'h1);
    bw(OFS_EVT_STATUS, 32'h1);
    `CHK("irq w1c", 1'b0, irq)
    test_done;
  end
endmodule : tb
`default_nettype wire
